// *** verification/autoselect_host_props.sv ***
// checker on the pins of the autoselect host
`timescale 1ns/1ps
module autoselect_host_props (
    // clock, reset and user side
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [2:0] req_kind,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_word0,
    input wire logic rsp_protected,
    input wire logic rsp_factory_lock,
    input wire logic rsp_customer_lock,
    // flash pins
    input wire logic [22:0] flash_addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic id_high_voltage
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire take = req_valid && req_ready; // accepted request
    property p_we; we_n; endproperty
    property p_pair; ce_n == oe_n; endproperty
    property p_rd; $fell(oe_n) |=> !oe_n ##1 oe_n; endproperty
    property p_lat; take && req_kind != 3'h1 |-> ##10 rsp_valid; endproperty
    property p_dev; take && req_kind == 3'h1 |-> ##18 rsp_valid; endproperty
    // address and voltage must already stand when the strobes are low
    property p_hold; !oe_n |-> $stable(flash_addr) &&
        $stable(id_high_voltage); endproperty
    property p_flag; rsp_valid |-> {rsp_protected, rsp_factory_lock,
        rsp_customer_lock} == {rsp_word0[0], rsp_word0[7], rsp_word0[6]};
    endproperty
    property p_lock; !oe_n && flash_addr[7:0] == 8'h03 |->
        flash_addr == 23'h004003; endproperty
    property p_prot; !oe_n && flash_addr[7:0] == 8'h02 |->
        flash_addr[11:0] == 12'h002; endproperty
    property p_mkr; !oe_n && flash_addr[7:0] == 8'h00 |->
        flash_addr[19:0] == 20'h0; endproperty
    property p_hv; req_ready |-> !id_high_voltage; endproperty
    a_we: assert property (p_we) else $error("we low");
    a_pair: assert property (p_pair) else $error("ce oe split");
    a_rd: assert property (p_rd) else $error("read length");
    a_lat: assert property (p_lat) else $error("word latency");
    a_dev: assert property (p_dev) else $error("dev latency");
    a_flag: assert property (p_flag) else $error("flag bits");
    a_lock: assert property (p_lock) else $error("lock addr");
    a_prot: assert property (p_prot) else $error("prot addr");
    a_mkr: assert property (p_mkr) else $error("maker addr");
    a_hv: assert property (p_hv) else $error("hv in idle");
    a_hold: assert property (p_hold) else $error("pin moved");
    c_dev: cover property (take && req_kind == 3'h1);
    c_prot: cover property (rsp_valid && rsp_protected);
    c_hv: cover property (!oe_n && id_high_voltage);
endmodule : autoselect_host_props
bind autoselect_host autoselect_host_props u_props (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_kind(req_kind), .rsp_valid(rsp_valid), .rsp_word0(rsp_word0),
    .rsp_protected(rsp_protected), .rsp_factory_lock(rsp_factory_lock),
    .rsp_customer_lock(rsp_customer_lock), .flash_addr(flash_addr),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .id_high_voltage(id_high_voltage)
);

// *** verification/flash_model.sv ***
// behavioural flash answering autoselect reads
`timescale 1ns/1ps
module flash_model (
    // clock for the bus keeper only
    input wire logic clk,
    // pins from the host
    input wire logic [22:0] flash_addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic id_high_voltage,
    // device state set by the bench
    input wire logic [2:0] bank_sel,
    input wire logic [10:0] prot_grp,
    input wire logic fact,
    input wire logic cust,
    output logic [15:0] dq
);
    // identity words: values are arbitrary
    parameter logic [15:0] MAKER = 16'h00a5, DEV1 = 16'h1357;
    parameter logic [15:0] DEV2 = 16'h2468, DEV3 = 16'h0c3c;
    logic [15:0] ans;
    logic [15:0] last_q = 16'h0;
    wire rd = !ce_n && !oe_n && we_n;
    // high voltage makes every bank answer
    wire in_bank = id_high_voltage ||
        flash_addr[22:20] == bank_sel;
    // answer decode, array data outside the bank
    always_comb
    begin
        ans = 16'hffff;
        if (in_bank)
            case (flash_addr[7:0])
                8'h00: ans = MAKER;
                8'h01: ans = DEV1;
                8'h0e: ans = DEV2;
                8'h0f: ans = DEV3;
                8'h02: ans = {15'h0000,
                    flash_addr[22:12] == prot_grp};
                8'h03: ans = {8'h0, fact, fact && cust, 6'h0};
                default: ans = 16'hffff;
            endcase
    end
    // released bus shows inverse of last word, never a stale copy
    assign dq = rd ? ans : ~last_q;
    always_ff @(posedge clk) if (rd) last_q <= ans;
endmodule : flash_model

// *** verification/tb_autoselect_host.sv ***
// bench for the autoselect host controller
`timescale 1ns/1ps
module tb_autoselect_host
    import autoselect_pkg::*;
;
    logic clk = 0, rst = 1, req_valid = 0, hv_mode = 0, fact = 0, cust = 0;
    logic [2:0] req_kind = 0, req_bank = 0, bank_sel = 0;
    logic [10:0] req_group = 0, prot_grp = 11'h7ff;
    logic req_ready, rsp_valid, rsp_protected, rsp_factory_lock, hv_seen;
    logic rsp_customer_lock, ce_n, oe_n, we_n, id_high_voltage;
    word_t rsp_word0, rsp_word1, rsp_word2, dq_in;
    logic [22:0] flash_addr;
    int failures = 0, num_checks = 0;
    initial forever #25 clk = ~clk;
    // design under test, every pin by name
    autoselect_host dut_u (
        .clk(clk), .rst(rst),
        .req_valid(req_valid), .req_ready(req_ready),
        .req_kind(req_kind), .req_bank(req_bank),
        .req_group(req_group), .hv_mode(hv_mode),
        .rsp_valid(rsp_valid), .rsp_word0(rsp_word0),
        .rsp_word1(rsp_word1), .rsp_word2(rsp_word2),
        .rsp_protected(rsp_protected),
        .rsp_factory_lock(rsp_factory_lock),
        .rsp_customer_lock(rsp_customer_lock),
        .flash_addr(flash_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .id_high_voltage(id_high_voltage), .dq_in(dq_in)
    );
    // far-side flash
    flash_model fm_u (
        .clk(clk), .flash_addr(flash_addr), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .id_high_voltage(id_high_voltage),
        .bank_sel(bank_sel), .prot_grp(prot_grp), .fact(fact),
        .cust(cust), .dq(dq_in)
    );
    task automatic check(input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // one request, wait for the answer pulse
    task automatic query(input logic [2:0] k, b, input logic [10:0] g,
        input logic hv);
        int n;
        @(negedge clk);
        req_kind = k;
        req_bank = b;
        req_group = g;
        hv_mode = hv;
        req_valid = 1;
        @(negedge clk);
        req_valid = 0;
        hv_seen = 0;
        for (n = 0; n < 40 && rsp_valid !== 1'b1; n++)
        begin
            @(negedge clk);
            if (oe_n === 1'b0) hv_seen = id_high_voltage;
        end
        check(16'(n < 40), 16'h0001);
        check(16'(hv_seen), 16'(hv));
    endtask : query
    // maker and device words, both entry methods
    task automatic t_ident;
        bank_sel = 3'h5;
        for (int h = 0; h < 2; h++)
        begin
            query(3'h0, 3'h5, 11'h000, h[0]);
            check(rsp_word0, fm_u.MAKER);
            query(3'h1, 3'h5, 11'h000, h[0]);
            check(rsp_word0, fm_u.DEV1);
            check(rsp_word1, fm_u.DEV2);
            check(rsp_word2, fm_u.DEV3);
        end
    endtask : t_ident
    // other banks keep showing array data
    task automatic t_bank;
        bank_sel = 3'h2;
        query(3'h0, 3'h6, 11'h000, 1'b0);
        check(rsp_word0, 16'hffff);
        query(3'h0, 3'h2, 11'h000, 1'b0);
        check(rsp_word0, fm_u.MAKER);
    endtask : t_bank
    // one protected group, neighbours unprotected
    task automatic t_prot;
        query(3'h2, 3'h0, 11'h7ff, 1'b1);
        check(rsp_word0, 16'h0001);
        check(16'(rsp_protected), 16'h0001);
        query(3'h2, 3'h0, 11'h7fe, 1'b1);
        check(rsp_word0, 16'h0000);
        query(3'h2, 3'h0, 11'h000, 1'b1);
        check(rsp_word0, 16'h0000);
    endtask : t_prot
    // all four lock combinations
    task automatic t_lock;
        bank_sel = 3'h0;
        for (int i = 0; i < 4; i++)
        begin
            fact = i[1];
            cust = i[0];
            query(3'h3, 3'h0, 11'h000, i[0]);
            check(rsp_word0, {8'h0, fact, fact & cust, 6'h0});
            check(16'({rsp_factory_lock, rsp_customer_lock}),
                16'({fact, fact & cust}));
        end
    endtask : t_lock
    initial
    begin
        repeat (2) @(negedge clk);
        rst = 0;
        t_ident();
        t_bank();
        t_prot();
        t_lock();
        final_report();
    end
    // watchdog against a hung handshake
    initial
    begin
        #100000;
        failures++;
        final_report();
    end
endmodule : tb_autoselect_host

// *** verilog/autoselect_host.sv ***
// host controller issuing autoselect reads to a parallel flash
`timescale 1ns/1ps
`include "autoselect_params.svh"
module autoselect_host
    import autoselect_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [2:0] req_kind,
    input wire logic [2:0] req_bank,
    input wire logic [10:0] req_group,
    input wire logic hv_mode,
    // user answer
    output logic rsp_valid,
    output logic [15:0] rsp_word0,
    output logic [15:0] rsp_word1,
    output logic [15:0] rsp_word2,
    output logic rsp_protected,
    output logic rsp_factory_lock,
    output logic rsp_customer_lock,
    // flash pins
    output logic [22:0] flash_addr,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic id_high_voltage,
    input wire logic [15:0] dq_in
);
    // controller states
    typedef enum logic [2:0] {
        S_IDLE,
        S_SETUP,
        S_READ,
        S_GAP,
        S_FETCH,
        S_DONE
    } state_e;

    state_e state_q, state_d;
    query_e kind_q;
    logic [2:0] bank_q;
    logic [10:0] group_q;
    logic hv_q;
    logic [1:0] idx_q; // word number within the query
    logic [`CNT_W-1:0] cnt_q; // strobe timing counter
    logic [1:0] nwords; // words this query needs
    logic [22:0] addr_w; // address of the next word to read
    logic hv_w; // voltage wanted after this edge
    logic [15:0] rsp0_q, rsp1_q, rsp2_q;
    logic valid_q;
    logic [1:0] fetch_q;
    logic [22:0] addr_q;
    logic hv_out_q;

    result_bus_if rbus ();

    result_mem u_mem (
        .clk(clk),
        .bus(rbus)
    );

    ////////////////////////////////////////////////////////////////
    // address forming, used by the maker and device queries
    function automatic logic [22:0] form_addr(input logic [2:0] bank,
        input logic [7:0] ofs);
        form_addr = {bank, 12'h000, ofs};
    endfunction : form_addr

    // full address of one word; used on take and for later words
    function automatic logic [22:0] query_addr(input query_e kind,
        input logic [2:0] bank, input logic [10:0] group,
        input logic [1:0] idx);
        logic [7:0] ofs;
        // maker keeps A0-A3, A6, A7 low
        ofs = (kind == Q_MAKER) ? `OFS_MAKER :
            (kind == Q_PROT) ? `OFS_PROT :
            (kind == Q_LOCK) ? `OFS_LOCK :
            (idx == 2'h0) ? `OFS_DEV1 :
            (idx == 2'h1) ? `OFS_DEV2 : `OFS_DEV3;
        // protection query carries the group on A22-A12
        if (kind == Q_PROT)
            query_addr = {group, 4'h0, ofs};
        else if (kind == Q_LOCK)
            query_addr = `LOCK_BANK_ADDR | 23'(ofs);
        else
            query_addr = form_addr(bank, ofs);
    endfunction : query_addr

    // word count per query kind
    assign nwords = (kind_q == Q_DEVICE) ? 2'h3 : 2'h1;

    // next address: from the request on take, else the following word
    assign addr_w = (state_q == S_IDLE) ?
        query_addr(query_e'(req_kind), req_bank, req_group, 2'h0) :
        query_addr(kind_q, bank_q, group_q, idx_q + 2'h1);

    // voltage from take until the last gap; on take the request decides
    assign hv_w = (state_d inside {S_SETUP, S_READ, S_GAP}) &&
        (req_ready ? hv_mode : hv_q);

    assign req_ready = (state_q == S_IDLE);

    ////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: if (req_valid) state_d = S_SETUP;
            S_SETUP: state_d = S_READ; // address settles before strobes
            S_READ: if (cnt_q == `CNT_W'(`RD_CYC - 1)) state_d = S_GAP;
            S_GAP:
                if (cnt_q == `CNT_W'(`GAP_CYC - 1))
                    state_d = (idx_q == nwords - 2'h1) ? S_FETCH : S_SETUP;
            S_FETCH: if (fetch_q == 2'h3) state_d = S_DONE;
            S_DONE: state_d = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // request capture and sequencing
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= S_IDLE;
            kind_q <= Q_MAKER;
            bank_q <= 3'h0;
            group_q <= 11'h000;
            hv_q <= 1'b0;
            idx_q <= 2'h0;
            cnt_q <= '0;
            fetch_q <= 2'h0;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == S_IDLE && req_valid)
            begin
                kind_q <= query_e'(req_kind);
                bank_q <= req_bank;
                group_q <= req_group;
                hv_q <= hv_mode;
                idx_q <= 2'h0;
                fetch_q <= 2'h0;
            end
            // timer restarts at every state change
            cnt_q <= (state_d != state_q) ? '0 : cnt_q + `CNT_W'(1);
            if (state_q == S_GAP && state_d == S_SETUP)
                idx_q <= idx_q + 2'h1;
            if (state_q == S_FETCH)
                fetch_q <= fetch_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // pins: address and high voltage held before and during reads
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            addr_q <= 23'h000000;
            hv_out_q <= 1'b0;
        end
        else
        begin
            // loaded one cycle early so pins settle before strobes fall
            if (state_d == S_SETUP)
                addr_q <= addr_w;
            // voltage applied from setup until the last gap ends
            hv_out_q <= hv_w;
        end
    end

    assign flash_addr = addr_q;
    assign id_high_voltage = hv_out_q;
    // plain read cycle strobes
    assign ce_n = !(state_q == S_READ);
    assign oe_n = !(state_q == S_READ);
    assign we_n = 1'b1;

    ////////////////////////////////////////////////////////////////
    // capture last data of each read into memory
    assign rbus.wr_en = (state_q == S_READ) &&
        (cnt_q == `CNT_W'(`RD_CYC - 1));
    assign rbus.wr_addr = {1'b0, idx_q};
    assign rbus.wr_data = dq_in;
    assign rbus.rd_addr = {1'b0, fetch_q};

    ////////////////////////////////////////////////////////////////
    // answer registers, loaded from memory read-back
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rsp0_q <= 16'h0000;
            rsp1_q <= 16'h0000;
            rsp2_q <= 16'h0000;
            valid_q <= 1'b0;
        end
        else
        begin
            // read data lags address by one cycle
            if (state_q == S_FETCH && fetch_q == 2'h1)
                rsp0_q <= rbus.rd_data;
            if (state_q == S_FETCH && fetch_q == 2'h2)
                rsp1_q <= rbus.rd_data;
            if (state_q == S_FETCH && fetch_q == 2'h3)
                rsp2_q <= rbus.rd_data;
            valid_q <= (state_q == S_DONE);
        end
    end

    assign rsp_valid = valid_q;
    assign rsp_word0 = rsp0_q;
    assign rsp_word1 = rsp1_q;
    assign rsp_word2 = rsp2_q;
    // zero word means unprotected; fresh parts read zero
    assign rsp_protected = rsp0_q[`PROT_BIT];
    assign rsp_factory_lock = rsp0_q[`FACTORY_BIT];
    assign rsp_customer_lock = rsp0_q[`CUSTOMER_BIT];
endmodule : autoselect_host

// *** verilog/autoselect_params.svh ***
// constants for the autoselect query controller
`ifndef AUTOSELECT_PARAMS_SVH
`define AUTOSELECT_PARAMS_SVH
`define ADDR_W 23
`define DATA_W 16
`define BANK_MSB 22
`define BANK_LSB 20
`define GROUP_MSB 22
`define GROUP_LSB 12
`define GROUP_W 11
// low word offsets of the identifier words
`define OFS_MAKER 8'h00
`define OFS_DEV1 8'h01
`define OFS_DEV2 8'h0e
`define OFS_DEV3 8'h0f
`define OFS_PROT 8'h02
`define OFS_LOCK 8'h03
// data bits of the answers
`define PROT_BIT 0
`define FACTORY_BIT 7
`define CUSTOMER_BIT 6
// bank address used when polling the lock indicator
`define LOCK_BANK_ADDR 23'h004000
// read cycle timing: strobes low 100 ns, gap 50 ns
`define T_RD_NS 100
`define T_GAP_NS 50
`define CLK_NS 50
`define RD_CYC ((`T_RD_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_CYC ((`T_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 4
`define RES_DEPTH 8
`define RES_AW 3
`endif

// *** verilog/autoselect_pkg.sv ***
// types shared by the autoselect query controller
package autoselect_pkg;
    // kinds of query the controller can run
    typedef enum logic [2:0] {
        Q_MAKER,
        Q_DEVICE,
        Q_PROT,
        Q_LOCK
    } query_e;
    // one stored answer word
    typedef logic [15:0] word_t;
endpackage : autoselect_pkg

// *** verilog/result_bus_if.sv ***
// carrier between controller and its answer memory
`timescale 1ns/1ps
interface result_bus_if;
    logic wr_en;
    logic [2:0] wr_addr;
    logic [15:0] wr_data;
    logic [2:0] rd_addr;
    logic [15:0] rd_data;
    modport master (output wr_en, output wr_addr, output wr_data,
        output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data,
        input rd_addr, output rd_data);
endinterface : result_bus_if

// *** verilog/result_mem.sv ***
// small answer memory with registered read data
`timescale 1ns/1ps
`include "autoselect_params.svh"
module result_mem
    import autoselect_pkg::*;
(
    // clock
    input wire logic clk,
    // carrier
    result_bus_if.mem bus
);
    // storage words
    word_t mem_q [`RES_DEPTH];
    word_t rd_q;

    ////////////////////////////////////////////////////////////////
    // write port and registered read
    always_ff @(posedge clk)
    begin
        if (bus.wr_en)
        begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
        rd_q <= mem_q[bus.rd_addr];
    end

    assign bus.rd_data = rd_q;
endmodule : result_mem
